// File: design/nmi_ext_sources.sv
// Extended NMI sources: fail-safe, bus time-out and software NMI with master gate.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Fail-safe terminal count sets status bit 7 and NMI when enabled.
// - Bus master holding the bus over 8 us raises bus time-out, bit 6.
// - Slave not releasing the bus within 32 us also raises bus time-out.
// - Control bit 3 gates both time-out kinds; cleared means no NMI.
// - Bit 4 records whether master or slave time-out caused it.
// - Write to port 462 hex sets bit 5 and NMI if enabled.
// - Combined NMI drives interrupt request two; each source maskable.
// - Master enable bit 7 behind the RTC address port gates all sources.
module nmi_ext_sources
  import nmi_ext_pkg::*;
#(
  parameter int BM_CYCLES = BM_TIMEOUT_CYC,
  parameter int SLAVE_CYCLES = SLAVE_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  input wire logic failsafe_tc_i,
  input wire logic bus_master_hold_i,
  input wire logic slave_hold_i,
  output logic [6:0] rtc_index_o,
  output logic cpu_interrupt_request_two_o
);

  function automatic logic io_hit(input io_req_t r, input logic [15:0] port);
    return r.addr == port;
  endfunction

  logic failsafe_timeout_flag_q;
  logic bus_timeout_flag_q;
  logic software_triggered_flag_q;
  logic timeout_kind_q;
  logic bt_en_q;
  logic fs_en_q;
  logic sw_en_q;
  logic master_en_q;
  logic [6:0] rtc_index_q;
  logic [7:0] rdata_q;
  logic nmi_q;
  logic bm_expire;
  logic slave_expire;
  logic csr_wr;
  logic sw_trig;
  logic bt_event;
  logic any_pending;
  logic [7:0] csr_val;

  assign csr_wr = io_req_i.wr && io_hit(io_req_i, EXT_CSR_PORT);
  assign sw_trig = io_req_i.wr && io_hit(io_req_i, SW_TRIG_PORT);

  hold_timer #(.LIMIT(BM_CYCLES)) u_bm_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .hold_i(bus_master_hold_i),
    .expire_o(bm_expire)
  );

  hold_timer #(.LIMIT(SLAVE_CYCLES)) u_slave_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .hold_i(slave_hold_i),
    .expire_o(slave_expire)
  );

  // Time-outs only count as events while their shared enable is set.
  assign bt_event = (bm_expire || slave_expire) && bt_en_q;

  // Enables are written through the CSR; clearing an enable also clears its flag.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bt_en_q <= ENABLE_RST;
      fs_en_q <= ENABLE_RST;
      sw_en_q <= ENABLE_RST;
    end else if (csr_wr) begin
      bt_en_q <= io_req_i.wdata[BT_EN_BIT];
      fs_en_q <= io_req_i.wdata[FS_EN_BIT];
      sw_en_q <= io_req_i.wdata[SW_EN_BIT];
    end
  end

  // A source event in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      failsafe_timeout_flag_q <= 1'b0;
    end else if (failsafe_tc_i && fs_en_q) begin
      failsafe_timeout_flag_q <= 1'b1;
    end else if (csr_wr && !io_req_i.wdata[FS_EN_BIT]) begin
      failsafe_timeout_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_timeout_flag_q <= 1'b0;
    end else if (bt_event) begin
      bus_timeout_flag_q <= 1'b1;
    end else if (csr_wr && !io_req_i.wdata[BT_EN_BIT]) begin
      bus_timeout_flag_q <= 1'b0;
    end
  end

  // When both kinds expire together the slave is reported.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_kind_q <= KIND_MASTER;
    end else if (bt_event) begin
      timeout_kind_q <= slave_expire ? KIND_SLAVE : KIND_MASTER;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      software_triggered_flag_q <= 1'b0;
    end else if (sw_trig && sw_en_q) begin
      software_triggered_flag_q <= 1'b1;
    end else if (csr_wr && !io_req_i.wdata[SW_EN_BIT]) begin
      software_triggered_flag_q <= 1'b0;
    end
  end

  // Low bits select the clock register; the NMI logic only needs bit 7.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      master_en_q <= ENABLE_RST;
      rtc_index_q <= RTC_INDEX_RST;
    end else if (io_req_i.wr && io_hit(io_req_i, RTC_ADDR_PORT)) begin
      master_en_q <= io_req_i.wdata[MASTER_EN_BIT];
      rtc_index_q <= io_req_i.wdata[6:0];
    end
  end

  always_comb begin
    csr_val = 8'h00;
    csr_val[FS_FLAG_BIT] = failsafe_timeout_flag_q;
    csr_val[BT_FLAG_BIT] = bus_timeout_flag_q;
    csr_val[SW_FLAG_BIT] = software_triggered_flag_q;
    csr_val[KIND_BIT] = timeout_kind_q;
    csr_val[BT_EN_BIT] = bt_en_q;
    csr_val[FS_EN_BIT] = fs_en_q;
    csr_val[SW_EN_BIT] = sw_en_q;
  end

  // Read data stays until the next read; other ports read as zero.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= RDATA_RST;
    end else if (io_req_i.rd) begin
      rdata_q <= io_hit(io_req_i, EXT_CSR_PORT) ? csr_val : 8'h00;
    end
  end

  assign any_pending = (failsafe_timeout_flag_q && fs_en_q)
                    || (bus_timeout_flag_q && bt_en_q)
                    || (software_triggered_flag_q && sw_en_q);

  // Registered so the processor input never sees decode glitches.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= master_en_q && any_pending;
    end
  end

  assign cpu_interrupt_request_two_o = nmi_q;
  assign io_rdata_o = rdata_q;
  assign rtc_index_o = rtc_index_q;

  // Independent run-length counters for checking the time-out figures.
  localparam int RW = $clog2(SLAVE_CYCLES + 1);
  logic [RW-1:0] bm_run_q;
  logic [RW-1:0] sl_run_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bm_run_q <= '0;
      sl_run_q <= '0;
    end else begin
      bm_run_q <= !bus_master_hold_i ? '0 : (bm_run_q == RW'(BM_CYCLES) ? bm_run_q : bm_run_q + 1'b1);
      sl_run_q <= !slave_hold_i ? '0 : (sl_run_q == RW'(SLAVE_CYCLES) ? sl_run_q : sl_run_q + 1'b1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_failsafe;
    failsafe_tc_i && fs_en_q |=> failsafe_timeout_flag_q ##0 csr_val[FS_FLAG_BIT];
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("failsafe flag not set");

  property p_bm_timeout;
    (bus_master_hold_i && bm_run_q == RW'(BM_CYCLES - 1) ##1 bt_en_q) |=> bus_timeout_flag_q;
  endproperty
  a_bm_timeout: assert property (p_bm_timeout) else $error("master time-out missed");

  property p_bm_early;
    (bm_run_q < RW'(BM_CYCLES - 1)) && !slave_expire |=> !bm_expire;
  endproperty
  a_bm_early: assert property (p_bm_early) else $error("master time-out too early");

  property p_slave_timeout;
    (slave_hold_i && sl_run_q == RW'(SLAVE_CYCLES - 1) ##1 bt_en_q)
      |=> bus_timeout_flag_q && timeout_kind_q == KIND_SLAVE;
  endproperty
  a_slave_timeout: assert property (p_slave_timeout) else $error("slave time-out missed");

  property p_bt_gate;
    !bt_en_q |=> !$rose(bus_timeout_flag_q);
  endproperty
  a_bt_gate: assert property (p_bt_gate) else $error("time-out set while disabled");

  property p_kind_master;
    bm_expire && !slave_expire && bt_en_q |=> timeout_kind_q == KIND_MASTER;
  endproperty
  a_kind_master: assert property (p_kind_master) else $error("kind not master");

  sequence s_sw_write;
    sw_trig && sw_en_q;
  endsequence

  sequence s_sw_seen;
    software_triggered_flag_q && master_en_q && sw_en_q;
  endsequence

  property p_sw_nmi;
    s_sw_write ##1 s_sw_seen |=> cpu_interrupt_request_two_o;
  endproperty
  a_sw_nmi: assert property (p_sw_nmi) else $error("software NMI not raised");

  property p_masked;
    !any_pending |=> !cpu_interrupt_request_two_o;
  endproperty
  a_masked: assert property (p_masked) else $error("NMI without enabled source");

  property p_master_off;
    !master_en_q |=> !cpu_interrupt_request_two_o;
  endproperty
  a_master_off: assert property (p_master_off) else $error("NMI while master disabled");

  property p_hold;
    master_en_q && any_pending && !csr_wr && !io_req_i.wr
      |=> cpu_interrupt_request_two_o ##1 cpu_interrupt_request_two_o;
  endproperty
  a_hold: assert property (p_hold) else $error("NMI dropped while pending");

endmodule
`default_nettype wire

// File: design/nmi_ext_pkg.sv
// Package with port addresses, bit positions, reset values and timing constants for the NMI block.
package nmi_ext_pkg;

  localparam logic [15:0] EXT_CSR_PORT = 16'h0461;
  localparam logic [15:0] SW_TRIG_PORT = 16'h0462;
  localparam logic [15:0] RTC_ADDR_PORT = 16'h0070;

  localparam int FS_FLAG_BIT = 7;
  localparam int BT_FLAG_BIT = 6;
  localparam int SW_FLAG_BIT = 5;
  localparam int KIND_BIT = 4;
  localparam int BT_EN_BIT = 3;
  localparam int FS_EN_BIT = 2;
  localparam int SW_EN_BIT = 1;
  localparam int MASTER_EN_BIT = 7;

  localparam logic ENABLE_RST = 1'b0;
  localparam logic KIND_MASTER = 1'b0;
  localparam logic KIND_SLAVE = 1'b1;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [6:0] RTC_INDEX_RST = 7'h00;

  localparam int CLK_PERIOD_NS = 8;
  localparam int BM_TIMEOUT_NS = 8000;
  localparam int SLAVE_TIMEOUT_NS = 32000;
  // Least times: round up to whole cycles.
  localparam int BM_TIMEOUT_CYC = (BM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLAVE_TIMEOUT_CYC = (SLAVE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage

// File: design/hold_timer.sv
// Counts consecutive cycles of a held condition and pulses once when a limit is reached.
`timescale 1ns/100ps
`default_nettype none

module hold_timer #(
  parameter int LIMIT = 1000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hold_i,
  output logic expire_o
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count_q;
  logic expire_q;

  // The counter stops at the limit so one long hold gives a single pulse.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= '0;
    end else if (!hold_i) begin
      count_q <= '0;
    end else if (count_q != CW'(LIMIT)) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= hold_i && (count_q == LAST);
    end
  end

  assign expire_o = expire_q;

endmodule
`default_nettype wire

// File: tb/bus_side_model.sv
// Far-side model: bus owners that hold the bus and the fail-safe timer pulse.
`timescale 1ns/100ps
`default_nettype none
module bus_side_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] sel_i,
  input wire logic [7:0] len_i,
  output logic failsafe_tc_o = 1'b0,
  output logic bus_master_hold_o = 1'b0,
  output logic slave_hold_o = 1'b0
);
  logic [7:0] left_q = 8'h00;
  logic [1:0] sel_q = 2'h0;
  always @(posedge clk_i) begin
    if (go_i) begin
      left_q <= len_i;
      sel_q <= sel_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // Levels move on the falling edge so the block never samples a changing line.
  always @(negedge clk_i) begin
    failsafe_tc_o <= (left_q != 8'h00) && (sel_q == 2'h0);
    bus_master_hold_o <= (left_q != 8'h00) && (sel_q == 2'h1);
    slave_hold_o <= (left_q != 8'h00) && (sel_q == 2'h2);
  end
endmodule
`default_nettype wire

// File: tb/nmi_ext_sources_tb.sv
// Self-checking bench for the extended NMI sources.
`timescale 1ns/100ps
`default_nettype none
module nmi_ext_sources_tb
  import nmi_ext_pkg::*;
;
  localparam logic [7:0] BM_N = 8'h08;
  localparam logic [7:0] SL_N = 8'h10;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  io_req_t req = '0;
  logic [7:0] rdata;
  logic [6:0] rtc_idx;
  logic irq, fs_tc, bm_hold, sl_hold;
  logic go = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] len = 8'h00;
  logic fs_flag = 1'b0, bt = 1'b0, sw = 1'b0, kind = 1'b0, master = 1'b0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] d;
  int failures = 0;
  int n_compared = 0;

  nmi_ext_sources #(.BM_CYCLES(8), .SLAVE_CYCLES(16)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .io_req_i(req), .io_rdata_o(rdata), .failsafe_tc_i(fs_tc), .bus_master_hold_i(bm_hold),
    .slave_hold_i(sl_hold), .rtc_index_o(rtc_idx), .cpu_interrupt_request_two_o(irq));
  bus_side_model u_far (.clk_i(clk_i), .go_i(go), .sel_i(sel), .len_i(len),
    .failsafe_tc_o(fs_tc), .bus_master_hold_o(bm_hold), .slave_hold_o(sl_hold));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_csr();
    return {fs_flag, bt, sw, kind, 4'h0} | ctl;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk_i);
    req.wr = 1'b0;
    if (a == EXT_CSR_PORT) begin
      ctl = v & 8'h0e;
      fs_flag &= v[FS_EN_BIT];
      bt &= v[BT_EN_BIT];
      sw &= v[SW_EN_BIT];
    end
    if (a == SW_TRIG_PORT) sw |= ctl[SW_EN_BIT];
    if (a == RTC_ADDR_PORT) master = v[MASTER_EN_BIT];
    if (a == RTC_ADDR_PORT) check({1'b0, rtc_idx}, {1'b0, v[6:0]});
  endtask

  // Waits out the flag and output register stages before each read.
  task automatic rd(input logic [15:0] a);
    repeat (3) @(negedge clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    req.rd = 1'b0;
    check(rdata, (a == EXT_CSR_PORT) ? exp_csr() : 8'h00);
    check({7'h00, irq}, {7'h00, master && (fs_flag || bt || sw)});
  endtask

  task automatic hold(input logic [1:0] s, input logic [7:0] n);
    @(negedge clk_i);
    go = 1'b1;
    sel = s;
    len = n;
    @(negedge clk_i);
    go = 1'b0;
    repeat (n) @(negedge clk_i);
    if (s == 2'h0) fs_flag |= ctl[FS_EN_BIT];
    if (s != 2'h0 && n >= ((s == 2'h1) ? BM_N : SL_N) && ctl[BT_EN_BIT]) begin
      bt = 1'b1;
      kind = (s == 2'h2);
    end
  endtask

  initial begin
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b1;
    d = $urandom(32'hfbf9);
    rd(EXT_CSR_PORT);
    wr(EXT_CSR_PORT, 8'hff);
    rd(EXT_CSR_PORT);
    hold(2'h1, BM_N - 8'h01);
    rd(EXT_CSR_PORT);
    hold(2'h1, BM_N);
    rd(EXT_CSR_PORT);
    wr(RTC_ADDR_PORT, 8'h80);
    rd(EXT_CSR_PORT);
    wr(EXT_CSR_PORT, 8'h06);
    hold(2'h2, SL_N);
    rd(EXT_CSR_PORT);
    wr(EXT_CSR_PORT, 8'h0e);
    hold(2'h2, SL_N - 8'h01);
    rd(EXT_CSR_PORT);
    hold(2'h2, SL_N);
    hold(2'h0, 8'h01);
    wr(SW_TRIG_PORT, 8'h5a);
    rd(EXT_CSR_PORT);
    wr(EXT_CSR_PORT, 8'h00);
    wr(SW_TRIG_PORT, 8'h01);
    rd(EXT_CSR_PORT);
    rd(16'h0463);
    rd(SW_TRIG_PORT);
    for (int i = 0; i < 60; i++) begin
      d = $urandom;
      case ($urandom % 5)
        0: wr(EXT_CSR_PORT, d);
        1: wr(SW_TRIG_PORT, d);
        2: wr(RTC_ADDR_PORT, d);
        3: hold(2'($urandom % 3), 8'h01 + 8'(d % 20));
        default: wr(16'h0463, d);
      endcase
      rd(EXT_CSR_PORT);
    end
    summarize();
  end

  initial begin
    #(20000 * 8);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
